/* hdl/dcs_clock_sysref_ctrl.sv */
/*
 * Control-register slice for the DAC clock tree, system-reference
 * receiver and DAC PLL band recalibration.
 * Assumes the serial-port decoder presents single-cycle byte writes and
 * reads on a plain register port clocked by clk_sys, and that sysref_in
 * is already synchronous to clk_sys.
 */
// Summary of operation
// - Calibration reference power-down gates its clock
// - Receiver power-down disables clock input buffer
// - Sync enable passes sysref timing to RF
// - Divider enable halves input for sampling
// - Sysref receiver off while power-down set
// - Hysteresis enable applies programmed hysteresis amount
// - Edge select picks rising or falling alignment
// - Each hysteresis bit adds ten millivolts
// - Hysteresis high bits low, low byte next
// - Recalibrate restarts only VCO band calibration
module dcs_clock_sysref_ctrl (
    // Clock and reset
    input  wire logic                    clk_sys,
    input  wire logic                    reset,
    // Register port
    input  wire logic [dcs_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [dcs_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                    reg_write,
    input  wire logic                    reg_read,
    output logic      [dcs_pkg::DATA_W-1:0] reg_rdata,
    output logic                         reg_rdata_valid,
    // System-reference input
    input  wire logic                    sysref_in,
    // Analog and clock-tree controls
    output dcs_pkg::dcs_clock_ctrl_t     clock_ctrl,
    output dcs_pkg::dcs_sysref_ctrl_t    sysref_ctrl,
    output logic                         sysref_align_pulse,
    output logic                         rf_sync_pulse,
    output logic                         vco_band_recal_start
);
    import dcs_pkg::*;

    // ==========================================================
    // Register state
    logic       cal_ref_clock_powerdown_reg;
    logic       clock_receiver_powerdown_reg;
    logic       duty_cycle_enable_reg;
    logic       rf_chain_sync_enable_reg;
    logic       rf_divide_by_two_enable_reg;
    logic       sysref_receiver_powerdown_reg;
    logic       hysteresis_enable_reg;
    logic       sysref_edge_select_reg;
    logic [1:0] hysteresis_amount_high_reg;
    logic [7:0] hysteresis_amount_low_reg;
    logic       vco_band_recalibrate_reg;

    logic wr_clk;
    logic wr_sys;
    logic wr_hys;
    logic wr_pll;

    assign wr_clk = reg_write && (reg_addr == CLOCK_CONFIG_POWER_ADDR);
    assign wr_sys = reg_write && (reg_addr == SYSREF_RECEIVER_CONTROL_ADDR);
    assign wr_hys = reg_write && (reg_addr == SYSREF_HYSTERESIS_LOW_ADDR);
    assign wr_pll = reg_write && (reg_addr == DAC_PLL_CONTROL_ADDR);

    // ==========================================================
    // Clock configuration register
    // Duty-cycle enable is stored as written; keeping it at one is up to software
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cal_ref_clock_powerdown_reg  <= RST_CAL_REF_PD;
            clock_receiver_powerdown_reg <= RST_CLK_REC_PD;
            duty_cycle_enable_reg        <= RST_DUTY_EN;
            rf_chain_sync_enable_reg     <= RST_RF_CHAIN_SYNC_ENABLE;
            rf_divide_by_two_enable_reg  <= RST_RF_DIV2_EN;
        end else if (wr_clk) begin
            cal_ref_clock_powerdown_reg  <= reg_wdata[CAL_REF_PD_BIT];
            clock_receiver_powerdown_reg <= reg_wdata[CLK_REC_PD_BIT];
            duty_cycle_enable_reg        <= reg_wdata[DUTY_EN_BIT];
            rf_chain_sync_enable_reg     <= reg_wdata[RF_CHAIN_SYNC_ENABLE_BIT];
            rf_divide_by_two_enable_reg  <= reg_wdata[RF_DIV2_EN_BIT];
        end
    end

    // ==========================================================
    // System-reference receiver registers
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sysref_receiver_powerdown_reg <= RST_SYSREF_PD;
            hysteresis_enable_reg         <= RST_HYS_EN;
            sysref_edge_select_reg        <= RST_EDGE_SEL;
            hysteresis_amount_high_reg    <= RST_HYS_HIGH;
        end else if (wr_sys) begin
            sysref_receiver_powerdown_reg <= reg_wdata[SYSREF_PD_BIT];
            hysteresis_enable_reg         <= reg_wdata[HYS_EN_BIT];
            sysref_edge_select_reg        <= reg_wdata[EDGE_SEL_BIT];
            hysteresis_amount_high_reg    <= reg_wdata[HYS_HIGH_MSB:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            hysteresis_amount_low_reg <= RST_HYS_LOW;
        end else if (wr_hys) begin
            hysteresis_amount_low_reg <= reg_wdata;
        end
    end

    // ==========================================================
    // DAC PLL control and band recalibration trigger
    // Only a rising write starts a run; rewriting one does nothing, so
    // software writes zero before asking for another calibration.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            vco_band_recalibrate_reg <= RST_RECAL;
            vco_band_recal_start     <= 1'b0;
        end else begin
            vco_band_recal_start <= wr_pll && reg_wdata[RECAL_BIT]
                                    && !vco_band_recalibrate_reg;
            if (wr_pll) begin
                vco_band_recalibrate_reg <= reg_wdata[RECAL_BIT];
            end
        end
    end

    // ==========================================================
    // Read-back, one cycle after the request; unmapped reads give zero
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            reg_rdata       <= 8'h00;
            reg_rdata_valid <= 1'b0;
        end else begin
            reg_rdata_valid <= reg_read;
            if (reg_read) begin
                case (reg_addr)
                    CLOCK_CONFIG_POWER_ADDR:
                        reg_rdata <= {3'h0, cal_ref_clock_powerdown_reg,
                                      clock_receiver_powerdown_reg, duty_cycle_enable_reg,
                                      rf_chain_sync_enable_reg, rf_divide_by_two_enable_reg};
                    SYSREF_RECEIVER_CONTROL_ADDR:
                        reg_rdata <= {3'h0, sysref_receiver_powerdown_reg,
                                      hysteresis_enable_reg, sysref_edge_select_reg,
                                      hysteresis_amount_high_reg};
                    SYSREF_HYSTERESIS_LOW_ADDR:
                        reg_rdata <= hysteresis_amount_low_reg;
                    DAC_PLL_CONTROL_ADDR:
                        reg_rdata <= {vco_band_recalibrate_reg, 7'h00};
                    default:
                        reg_rdata <= 8'h00;
                endcase
            end
        end
    end

    // ==========================================================
    // Clock-tree and analog control outputs
    logic [9:0] hys_amount;
    logic [6:0] hys_mv_next;

    assign hys_amount = {hysteresis_amount_high_reg, hysteresis_amount_low_reg};

    // Weight is a count of set bits, not a binary code
    always_comb begin
        hys_mv_next = 7'h00;
        for (int i = 0; i < HYS_BITS; i++) begin
            if (hys_amount[i]) begin
                hys_mv_next = hys_mv_next + HYS_STEP_MV;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            clock_ctrl  <= '0;
            sysref_ctrl <= '0;
        end else begin
            clock_ctrl.cal_ref_clock_enable         <= !cal_ref_clock_powerdown_reg;
            clock_ctrl.clock_receiver_buffer_enable <= !clock_receiver_powerdown_reg;
            clock_ctrl.duty_cycle_enable            <= duty_cycle_enable_reg;
            clock_ctrl.rf_chain_sync_enable         <= rf_chain_sync_enable_reg;
            clock_ctrl.rf_divide_by_two_enable      <= rf_divide_by_two_enable_reg;
            sysref_ctrl.receiver_enable             <= !sysref_receiver_powerdown_reg;
            sysref_ctrl.hysteresis_enable           <= hysteresis_enable_reg;
            sysref_ctrl.edge_select                 <= sysref_edge_select_reg;
            sysref_ctrl.hysteresis_amount           <= hys_amount;
            sysref_ctrl.hysteresis_millivolts       <= hysteresis_enable_reg ?
                                                       hys_mv_next : 7'h00;
        end
    end

    // ==========================================================
    // System-reference edge alignment
    logic sysref_prev_reg;
    logic align_next;

    always_comb begin
        align_next = 1'b0;
        if (!sysref_receiver_powerdown_reg) begin
            align_next = sysref_edge_select_reg ? (sysref_in && !sysref_prev_reg)
                                                : (!sysref_in && sysref_prev_reg);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sysref_prev_reg    <= 1'b0;
            sysref_align_pulse <= 1'b0;
            rf_sync_pulse      <= 1'b0;
        end else begin
            sysref_prev_reg    <= sysref_in;
            sysref_align_pulse <= align_next;
            rf_sync_pulse      <= align_next && rf_chain_sync_enable_reg;
        end
    end

    // ==========================================================
    // Checks
    property p_cal_ref;
        @(posedge clk_sys) disable iff (reset)
        wr_clk ##1 !reset ##1 1'b1 |-> clock_ctrl.cal_ref_clock_enable
                                       == !$past(reg_wdata[CAL_REF_PD_BIT], 2);
    endproperty
    a_cal_ref: assert property (p_cal_ref) else $error("cal ref clock enable wrong");

    property p_clk_rec;
        @(posedge clk_sys) disable iff (reset)
        wr_clk ##2 1'b1 |-> clock_ctrl.clock_receiver_buffer_enable
                           == !$past(reg_wdata[CLK_REC_PD_BIT], 2);
    endproperty
    a_clk_rec: assert property (p_clk_rec) else $error("receiver buffer enable wrong");

    property p_rf_sync;
        @(posedge clk_sys) disable iff (reset)
        rf_sync_pulse |-> sysref_align_pulse && $past(rf_chain_sync_enable_reg);
    endproperty
    a_rf_sync: assert property (p_rf_sync) else $error("rf sync without enable");

    property p_div2;
        @(posedge clk_sys) disable iff (reset)
        wr_clk ##2 1'b1 |-> clock_ctrl.rf_divide_by_two_enable
                           == $past(reg_wdata[RF_DIV2_EN_BIT], 2);
    endproperty
    a_div2: assert property (p_div2) else $error("divider enable wrong");

    property p_sysref_pd;
        @(posedge clk_sys) disable iff (reset)
        $past(sysref_receiver_powerdown_reg) |-> !sysref_align_pulse;
    endproperty
    a_sysref_pd: assert property (p_sysref_pd) else $error("align while powered down");

    property p_hys_off;
        @(posedge clk_sys) disable iff (reset)
        !sysref_ctrl.hysteresis_enable |-> sysref_ctrl.hysteresis_millivolts == 7'h00;
    endproperty
    a_hys_off: assert property (p_hys_off) else $error("hysteresis while disabled");

    property p_edge;
        @(posedge clk_sys) disable iff (reset)
        sysref_align_pulse |-> $past(sysref_in) != $past(sysref_prev_reg)
                               && $past(sysref_in) == $past(sysref_edge_select_reg);
    endproperty
    a_edge: assert property (p_edge) else $error("alignment on wrong edge");

    property p_hys_mv;
        @(posedge clk_sys) disable iff (reset)
        $past(hysteresis_enable_reg) |-> sysref_ctrl.hysteresis_millivolts
            == 7'($countones($past(hys_amount)) * 10);
    endproperty
    a_hys_mv: assert property (p_hys_mv) else $error("hysteresis millivolts wrong");

    property p_hys_split;
        @(posedge clk_sys) disable iff (reset)
        wr_hys ##1 1'b1 |-> hysteresis_amount_low_reg == $past(reg_wdata);
    endproperty
    a_hys_split: assert property (p_hys_split) else $error("low byte not stored");

    property p_recal;
        @(posedge clk_sys) disable iff (reset)
        wr_pll && reg_wdata[RECAL_BIT] && !vco_band_recalibrate_reg
            |=> vco_band_recal_start ##1 !vco_band_recal_start;
    endproperty
    a_recal: assert property (p_recal) else $error("recalibration pulse wrong");

    property p_recal_only_rise;
        @(posedge clk_sys) disable iff (reset)
        vco_band_recal_start |-> $past(wr_pll) && !$past(vco_band_recalibrate_reg);
    endproperty
    a_recal_only_rise: assert property (p_recal_only_rise) else $error("spurious recal");

endmodule // dcs_clock_sysref_ctrl

/* hdl/dcs_pkg.sv */
/*
 * Package for the DAC clock, system-reference and PLL control slice.
 * Holds register offsets, field positions, reset values and the carrier
 * structs. Assumes an 8-bit register port with byte-wide offsets.
 */
package dcs_pkg;

    // ==========================================================
    // Register port geometry
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 8;

    // ==========================================================
    // Register offsets
    localparam logic [11:0] CLOCK_CONFIG_POWER_ADDR      = 12'h080;
    localparam logic [11:0] SYSREF_RECEIVER_CONTROL_ADDR = 12'h081;
    localparam logic [11:0] SYSREF_HYSTERESIS_LOW_ADDR   = 12'h082;
    localparam logic [11:0] DAC_PLL_CONTROL_ADDR         = 12'h083;

    // ==========================================================
    // Field positions, clock_config_power
    localparam int unsigned CAL_REF_PD_BIT    = 4;
    localparam int unsigned CLK_REC_PD_BIT    = 3;
    localparam int unsigned DUTY_EN_BIT       = 2;
    localparam int unsigned RF_CHAIN_SYNC_ENABLE_BIT    = 1;
    localparam int unsigned RF_DIV2_EN_BIT    = 0;

    // Field positions, sysref_receiver_control
    localparam int unsigned SYSREF_PD_BIT     = 4;
    localparam int unsigned HYS_EN_BIT        = 3;
    localparam int unsigned EDGE_SEL_BIT      = 2;
    localparam int unsigned HYS_HIGH_MSB      = 1;

    // Field positions, dac_pll_control
    localparam int unsigned RECAL_BIT         = 7;

    // ==========================================================
    // Reset values
    localparam logic RST_CAL_REF_PD  = 1'b1;
    localparam logic RST_CLK_REC_PD  = 1'b1;
    localparam logic RST_DUTY_EN     = 1'b1;
    localparam logic RST_RF_CHAIN_SYNC_ENABLE  = 1'b1;
    localparam logic RST_RF_DIV2_EN  = 1'b0;
    localparam logic RST_SYSREF_PD   = 1'b1;
    localparam logic RST_HYS_EN      = 1'b0;
    localparam logic RST_EDGE_SEL    = 1'b0;
    localparam logic [1:0] RST_HYS_HIGH = 2'h0;
    localparam logic [7:0] RST_HYS_LOW  = 8'h00;
    localparam logic RST_RECAL       = 1'b0;

    // ==========================================================
    // Hysteresis scaling: each set control bit adds one step
    localparam int unsigned HYS_BITS    = 10;
    localparam logic [6:0]  HYS_STEP_MV = 7'h0a;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic cal_ref_clock_enable;
        logic clock_receiver_buffer_enable;
        logic duty_cycle_enable;
        logic rf_chain_sync_enable;
        logic rf_divide_by_two_enable;
    } dcs_clock_ctrl_t;

    typedef struct packed {
        logic       receiver_enable;
        logic       hysteresis_enable;
        logic       edge_select;
        logic [9:0] hysteresis_amount;
        logic [6:0] hysteresis_millivolts;
    } dcs_sysref_ctrl_t;

endpackage : dcs_pkg

/* sim/dcs_clock_sysref_ctrl_tb.sv */
/*
 * Self-checking bench for the clock, system-reference and PLL control slice.
 * Assumes dcs_pkg and dcs_clock_sysref_ctrl are compiled first; the bench
 * drives the register port and sysref_in itself, with no far-side model.
 */
module dcs_clock_sysref_ctrl_tb import dcs_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;

    // ==========================================================
    // Signals and register model
    logic                  clk_sys   = 1'b0;
    logic                  reset     = 1'b1;
    logic [ADDR_W-1:0]     reg_addr  = 12'h000;
    logic [DATA_W-1:0]     reg_wdata = 8'h00;
    logic                  reg_write = 1'b0;
    logic                  reg_read  = 1'b0;
    logic                  sysref_in = 1'b0;
    logic [DATA_W-1:0]     reg_rdata;
    logic                  reg_rdata_valid;
    dcs_clock_ctrl_t       clock_ctrl;
    dcs_sysref_ctrl_t      sysref_ctrl;
    logic                  sysref_align_pulse;
    logic                  rf_sync_pulse;
    logic                  vco_band_recal_start;
    logic [7:0]            m080, m081, m082, m083;
    logic [11:0]           addrs [5];
    int                    n_mismatch = 0;
    int                    n_compared = 0;
    int                    cycles     = 0;
    int                    seed       = 21;

    dcs_clock_sysref_ctrl DUT (
        .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .reg_rdata_valid(reg_rdata_valid), .sysref_in(sysref_in),
        .clock_ctrl(clock_ctrl), .sysref_ctrl(sysref_ctrl),
        .sysref_align_pulse(sysref_align_pulse), .rf_sync_pulse(rf_sync_pulse),
        .vco_band_recal_start(vco_band_recal_start)
    );

    always #25 clk_sys = ~clk_sys;

    // Whole run needs well under 3000 cycles; anything near 5000 is a hang
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_mismatch++;
            results();
        end
    end

    // ==========================================================
    // Expectations
    function automatic logic [7:0] rd_exp(input logic [11:0] a);
        case (a)
            CLOCK_CONFIG_POWER_ADDR:      return m080;
            SYSREF_RECEIVER_CONTROL_ADDR: return m081;
            SYSREF_HYSTERESIS_LOW_ADDR:   return m082;
            DAC_PLL_CONTROL_ADDR:         return m083;
            default:                      return 8'h00;
        endcase
    endfunction

    function automatic dcs_clock_ctrl_t exp_clk();
        return {~m080[4], ~m080[3], m080[2:0]};
    endfunction

    function automatic dcs_sysref_ctrl_t exp_sr();
        logic [9:0] amt;
        amt = {m081[1:0], m082};
        return {~m081[4], m081[3], m081[2], amt, m081[3] ? 7'(10 * $countones(amt)) : 7'h00};
    endfunction

    // ==========================================================
    // Compare tasks and verdict
    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_ctl(input logic [24:0] got, input logic [24:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_pls(input logic [3:0] got, input logic [3:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic results;
        $display("Comparisons %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ==========================================================
    // Register port drivers
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk_sys);
        reg_write <= 1'b0;
        // Reserved and unimplemented bits are dropped on write
        case (a)
            CLOCK_CONFIG_POWER_ADDR:      m080 = d & 8'h1f;
            SYSREF_RECEIVER_CONTROL_ADDR: m081 = d & 8'h1f;
            SYSREF_HYSTERESIS_LOW_ADDR:   m082 = d;
            DAC_PLL_CONTROL_ADDR:         m083 = d & 8'h80;
            default:                      ;
        endcase
    endtask

    task automatic rd_chk(input logic [11:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        #1;
        chk_pls(4'(reg_rdata_valid), 4'h1);
        chk_reg(reg_rdata, rd_exp(a));
        // Valid lasts one cycle while the data stands until the next read
        @(posedge clk_sys);
        #1;
        chk_pls(4'(reg_rdata_valid), 4'h0);
        chk_reg(reg_rdata, rd_exp(a));
    endtask

    task automatic wr_chk(input logic [11:0] a, input logic [7:0] d);
        logic fire;
        fire = (a == DAC_PLL_CONTROL_ADDR) && !m083[7] && d[7];
        wr(a, d);
        // The start pulse stands in the cycle right after the write edge
        #1;
        chk_pls(4'(vco_band_recal_start), 4'(fire));
        @(posedge clk_sys);
        #1;
        chk_pls(4'(vco_band_recal_start), 4'h0);
        chk_ctl({clock_ctrl, sysref_ctrl}, {exp_clk(), exp_sr()});
        rd_chk(a);
    endtask

    // One sysref transition under a given setup; pulses counted over four cycles
    task automatic sr_case(input logic pd, input logic sel, input logic sync, input logic rise);
        logic [3:0] n_al = 4'h0;
        logic [3:0] n_rf = 4'h0;
        logic       al;
        al = !pd && (rise == sel);
        wr(CLOCK_CONFIG_POWER_ADDR, {3'h0, m080[4:3], 1'b1, sync, m080[0]});
        wr(SYSREF_RECEIVER_CONTROL_ADDR, {3'h0, pd, m081[3], sel, m081[1:0]});
        @(posedge clk_sys);
        sysref_in <= !rise;
        repeat (4) @(posedge clk_sys);
        sysref_in <= rise;
        repeat (4) begin
            @(posedge clk_sys);
            #1;
            n_al += 4'(sysref_align_pulse);
            n_rf += 4'(rf_sync_pulse);
        end
        chk_pls(n_al, 4'(al));
        chk_pls(n_rf, 4'(al && sync));
        chk_ctl({clock_ctrl, sysref_ctrl}, {exp_clk(), exp_sr()});
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        logic [11:0] a;
        logic [7:0]  d;
        addrs = '{CLOCK_CONFIG_POWER_ADDR, SYSREF_RECEIVER_CONTROL_ADDR,
                  SYSREF_HYSTERESIS_LOW_ADDR, DAC_PLL_CONTROL_ADDR, 12'h0ff};
        m080 = 8'h1e;
        m081 = 8'h10;
        m082 = 8'h00;
        m083 = 8'h00;
        repeat (5) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
        chk_ctl({clock_ctrl, sysref_ctrl}, {exp_clk(), exp_sr()});
        for (int i = 0; i < 5; i++) rd_chk(addrs[i]);
        // Full hysteresis amount, then disabled, then the recalibrate sequence
        wr_chk(SYSREF_RECEIVER_CONTROL_ADDR, 8'h0b);
        wr_chk(SYSREF_HYSTERESIS_LOW_ADDR, 8'hff);
        wr_chk(SYSREF_RECEIVER_CONTROL_ADDR, 8'hf3);
        wr_chk(DAC_PLL_CONTROL_ADDR, 8'h80);
        wr_chk(DAC_PLL_CONTROL_ADDR, 8'hff);
        wr_chk(DAC_PLL_CONTROL_ADDR, 8'h00);
        wr_chk(DAC_PLL_CONTROL_ADDR, 8'h80);
        for (int i = 0; i < 80; i++) begin
            a = addrs[$unsigned($random(seed)) % 5];
            d = 8'($random(seed));
            if (a == CLOCK_CONFIG_POWER_ADDR) d[2] = 1'b1;
            wr_chk(a, d);
        end
        for (int i = 0; i < 16; i++) sr_case(i[0], i[1], i[2], i[3]);
        results();
    end
endmodule // dcs_clock_sysref_ctrl_tb
